// [nipc_top.sv]
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
// Behaviour
// - priority registers reset ones, upper four fixed
// - each vector owns a pair, index by address
// - stored pair uses current level encoding
// - codes 10,01,00,11 give levels zero to three
// - written level-zero pair keeps old value
// - reset and trap force level three
// - raised priority of running vector re-enters
// - enable, wait, halt load level zero
// - disable and trap load level three
// - popped flags restore both level bits
// - branch conditions test level three
// - level instructions hold until next change
// - fixed vectors, hardware order by address
// - pin groups, serial port, timers mapped
// - halt wake only by listed sources
// - active-halt wake depends on memory variant
// - four sensing modes per pin group
// - sensitivity writes only at level three
// - disabling pin group drops its latch
// - sensitivity resets zero, low bits cleared
// - bits 7:6 sense for third, fourth groups
// - third group invert flips sensing
// - bit 5 inverts third group
// - bits 4:3 sense for first, second groups
// - bit 2 inverts first group
module nipc_top #(
  parameter bit MASKED_ROM = 1'b0
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // CPU instruction strobes
  input  wire logic        enable_irq_instr,
  input  wire logic        disable_irq_instr,
  input  wire logic        wait_irq_instr,
  input  wire logic        halt_instr,
  input  wire logic        trap_instr,
  input  wire logic        pop_cc_instr,
  input  wire logic [1:0]  pop_cc_level,
  input  wire logic        irq_ack,
  // Peripheral requests
  input  wire logic        clock_time_base_irq,
  input  wire logic        sync_serial_irq,
  input  wire logic        timer_a_irq,
  input  wire logic        timer_b_irq,
  input  wire logic        async_serial_unit,
  // Port pins
  input  wire logic [15:0] ext_pins,
  // CPU side results
  output logic             irq_req,
  output logic [3:0]       irq_index,
  output logic [15:0]      irq_vector,
  output logic             current_level_high_bit,
  output logic             current_level_low_bit,
  output logic             branch_if_masked,
  output logic             branch_if_unmasked,
  output logic             wake_halt,
  output logic             wake_active_halt,
  output logic [15:0]      nmi_vector
);

  // ==========================================================
  // State
  logic [27:0] prio_q;
  logic [7:0]  sense_q;
  logic [1:0]  cur_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  logic        req_q;
  logic [3:0]  idx_q;
  logic [15:0] vec_q;
  logic        bm_q;
  logic        bu_q;
  logic        wh_q;
  logic        wah_q;
  logic [15:0] nmi_q;
  logic [13:0] src;
  logic [3:0]  best_idx;
  logic [1:0]  best_rank;
  logic        best_any;
  logic        wr_en;
  logic        setup;
  logic [3:0]  ext_clr;

  nipc_sense_if sif ();

  nipc_pin_sense u_sense (
    .clk  (clk),
    .rst  (rst),
    .pins (ext_pins),
    .sif  (sif.sense)
  );

  assign sif.sel = {sense_q[7:6], sense_q[7:6], sense_q[4:3], sense_q[4:3]};
  assign sif.inv = {1'b0, sense_q[5], 1'b0, sense_q[2]};
  assign sif.clr = ext_clr;

  // ==========================================================
  // APB slave, one wait-free access phase
  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pready_q & pwrite;

  always_ff @(posedge clk) begin
    if (rst) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= setup & ~pready_q;
      pslverr_q <= 1'b0;
      if (setup) begin
        prdata_q <= 32'h0000_0000;
        unique case (paddr)
          nipc_pkg::ADDR_PRIO0:  prdata_q[7:0] <= prio_q[7:0];
          nipc_pkg::ADDR_PRIO1:  prdata_q[7:0] <= prio_q[15:8];
          nipc_pkg::ADDR_PRIO2:  prdata_q[7:0] <= prio_q[23:16];
          nipc_pkg::ADDR_PRIO3:  prdata_q[7:0] <= nipc_pkg::PRIO3_RO_ONES | {4'h0, prio_q[27:24]};
          nipc_pkg::ADDR_SENSE:  prdata_q[7:0] <= sense_q;
          nipc_pkg::ADDR_STATUS: prdata_q[17:0] <= {src, 2'b00, cur_q};
          default:               pslverr_q <= 1'b1;
        endcase
      end
    end
  end

  // ==========================================================
  // Priority pairs; index 0 at the top vector
  genvar v;
  generate
    for (v = 0; v < nipc_pkg::NUM_VEC; v++) begin : g_pair
      logic       hit;
      logic [1:0] wd;
      assign hit = wr_en & (paddr == (nipc_pkg::ADDR_PRIO0 + 8'((v / 4) * 4)));
      assign wd  = pwdata[2*(v%4) +: 2];
      always_ff @(posedge clk) begin
        if (rst) begin
          prio_q[2*v +: 2] <= nipc_pkg::PRIO_RESET[1:0];
        end else if (hit && wd != nipc_pkg::LVL0) begin
          prio_q[2*v +: 2] <= wd;
        end
      end
      if (v >= 2 && v <= 5) begin : g_clr
        // Disabling a group or taking its request drops the latch
        assign ext_clr[v-2] = (hit & (wd == nipc_pkg::LVL3)) |
                              (irq_ack & req_q & (idx_q == 4'(v)));
      end
    end
  endgenerate

  // ==========================================================
  // Pin sensitivity, locked unless interrupts are off
  always_ff @(posedge clk) begin
    if (rst) begin
      sense_q <= nipc_pkg::SENSE_RESET;
    end else if (wr_en && paddr == nipc_pkg::ADDR_SENSE && cur_q == nipc_pkg::LVL3) begin
      sense_q <= pwdata[7:0] & nipc_pkg::SENSE_WMASK;
    end
  end

  // ==========================================================
  // Request sources by vector index
  always_comb begin
    src = 14'h0000;
    src[nipc_pkg::VEC_TIMEBASE] = clock_time_base_irq;
    src[nipc_pkg::VEC_EXT0 +: 4] = sif.req;
    src[nipc_pkg::VEC_SYNC] = sync_serial_irq;
    src[nipc_pkg::VEC_TIMA] = timer_a_irq;
    src[nipc_pkg::VEC_TIMB] = timer_b_irq;
    src[nipc_pkg::VEC_ASYNC] = async_serial_unit;
  end

  // Walk from lowest hardware order so higher order wins ties
  always_comb begin
    best_idx  = 4'h0;
    best_rank = 2'd0;
    best_any  = 1'b0;
    for (int i = 13; i >= 0; i--) begin
      if (src[i] && prio_q[2*i +: 2] != nipc_pkg::LVL3 &&
          (!best_any || nipc_pkg::rank(prio_q[2*i +: 2]) >= best_rank)) begin
        best_any  = 1'b1;
        best_idx  = 4'(i);
        best_rank = nipc_pkg::rank(prio_q[2*i +: 2]);
      end
    end
  end

  // ==========================================================
  // Current level; priority of writers is fixed
  always_ff @(posedge clk) begin
    if (rst) begin
      cur_q <= nipc_pkg::LVL3;
    end else if (trap_instr || disable_irq_instr) begin
      cur_q <= nipc_pkg::LVL3;
    end else if (enable_irq_instr || wait_irq_instr || halt_instr) begin
      cur_q <= nipc_pkg::LVL0;
    end else if (pop_cc_instr) begin
      cur_q <= pop_cc_level;
    end else if (irq_ack && req_q) begin
      cur_q <= prio_q[2*idx_q +: 2];
    end
  end

  // ==========================================================
  // Outputs toward the CPU
  // Re-entry of a running vector falls out of the compare: cur_q stays put
  always_ff @(posedge clk) begin
    if (rst) begin
      req_q <= 1'b0;
      idx_q <= 4'h0;
      vec_q <= nipc_pkg::VEC_RESET;
      nmi_q <= nipc_pkg::VEC_RESET;
    end else begin
      req_q <= best_any & (best_rank > nipc_pkg::rank(cur_q)) & ~(irq_ack & req_q);
      idx_q <= best_idx;
      vec_q <= nipc_pkg::VEC_ADDR_TOP - {11'h000, best_idx, 1'b0};
      nmi_q <= trap_instr ? nipc_pkg::VEC_TRAP : nipc_pkg::VEC_RESET;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      bm_q  <= 1'b1;
      bu_q  <= 1'b0;
      wh_q  <= 1'b0;
      wah_q <= 1'b0;
    end else begin
      bm_q  <= (cur_q == nipc_pkg::LVL3);
      bu_q  <= (cur_q != nipc_pkg::LVL3);
      wh_q  <= |(src & nipc_pkg::HALT_WAKE);
      wah_q <= |(src & (MASKED_ROM ? nipc_pkg::AHALT_ROM : nipc_pkg::AHALT_FLASH));
    end
  end

  assign prdata                 = prdata_q;
  assign pready                 = pready_q;
  assign pslverr                = pslverr_q;
  assign irq_req                = req_q;
  assign irq_index              = idx_q;
  assign irq_vector             = vec_q;
  assign current_level_high_bit = cur_q[1];
  assign current_level_low_bit  = cur_q[0];
  assign branch_if_masked       = bm_q;
  assign branch_if_unmasked     = bu_q;
  assign wake_halt              = wh_q;
  assign wake_active_halt       = wah_q;
  assign nmi_vector             = nmi_q;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_prio3_read;
    setup && !pwrite && paddr == nipc_pkg::ADDR_PRIO3 |=> prdata_q[7:4] == 4'hF;
  endproperty
  a_prio3_read: assert property (p_prio3_read) else $error("prio3 upper bits not ones");

  property p_lvl0_kept;
    wr_en && paddr == nipc_pkg::ADDR_PRIO0 && pwdata[1:0] == nipc_pkg::LVL0
      |=> prio_q[1:0] == $past(prio_q[1:0]);
  endproperty
  a_lvl0_kept: assert property (p_lvl0_kept) else $error("level zero pair stored");

  property p_ack_level;
    irq_ack && req_q && !trap_instr && !disable_irq_instr && !enable_irq_instr &&
      !wait_irq_instr && !halt_instr && !pop_cc_instr
      |=> cur_q == $past(prio_q[2*idx_q +: 2]);
  endproperty
  a_ack_level: assert property (p_ack_level) else $error("ack level mismatch");

  property p_enable;
    (enable_irq_instr || halt_instr) && !trap_instr && !disable_irq_instr
      |=> cur_q == nipc_pkg::LVL0;
  endproperty
  a_enable: assert property (p_enable) else $error("level zero not loaded");

  property p_disable;
    trap_instr || disable_irq_instr |=> cur_q == nipc_pkg::LVL3 ##1 bm_q;
  endproperty
  a_disable: assert property (p_disable) else $error("level three not loaded");

  property p_sense_lock;
    wr_en && paddr == nipc_pkg::ADDR_SENSE && cur_q != nipc_pkg::LVL3 |=> $stable(sense_q);
  endproperty
  a_sense_lock: assert property (p_sense_lock) else $error("sense written unlocked");

  property p_sense_rsvd;
    wr_en && paddr == nipc_pkg::ADDR_SENSE |=> sense_q[1:0] == 2'b00;
  endproperty
  a_sense_rsvd: assert property (p_sense_rsvd) else $error("reserved sense bits set");

  property p_req_above;
    req_q |-> nipc_pkg::rank(prio_q[2*idx_q +: 2]) > nipc_pkg::rank($past(cur_q)) ||
              $past(prio_q) != prio_q;
  endproperty
  a_req_above: assert property (p_req_above) else $error("request not above level");

  property p_branch;
    ##1 bm_q != bu_q && bm_q == ($past(cur_q) == nipc_pkg::LVL3);
  endproperty
  a_branch: assert property (p_branch) else $error("branch flags wrong");

  property p_pop;
    pop_cc_instr && !trap_instr && !disable_irq_instr && !enable_irq_instr &&
      !wait_irq_instr && !halt_instr |=> cur_q == $past(pop_cc_level);
  endproperty
  a_pop: assert property (p_pop) else $error("popped level not loaded");

  property p_trap_vec;
    trap_instr |=> nmi_q == nipc_pkg::VEC_TRAP;
  endproperty
  a_trap_vec: assert property (p_trap_vec) else $error("trap vector not shown");

  property p_ack_drop;
    irq_ack && req_q |=> !req_q;
  endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("request held after ack");

  property p_sense_wr;
    wr_en && paddr == nipc_pkg::ADDR_SENSE && cur_q == nipc_pkg::LVL3
      |=> sense_q == ($past(pwdata[7:0]) & nipc_pkg::SENSE_WMASK);
  endproperty
  a_sense_wr: assert property (p_sense_wr) else $error("sense write not taken");

  c_ack:   cover property (irq_ack && req_q);
  c_trap:  cover property (trap_instr);
  c_nest:  cover property (irq_ack && req_q ##[1:20] irq_ack && req_q);
  c_sense: cover property (wr_en && paddr == nipc_pkg::ADDR_SENSE && cur_q == nipc_pkg::LVL3);
  c_pop:   cover property (pop_cc_instr);

endmodule // nipc_top

// [nipc_pkg.sv]
package nipc_pkg;

  // ==========================================================
  // Register indices; the byte address is four times the index
  localparam logic [5:0] IDX_PRIO0 = 6'h24;
  localparam logic [5:0] IDX_PRIO1 = 6'h25;
  localparam logic [5:0] IDX_PRIO2 = 6'h26;
  localparam logic [5:0] IDX_PRIO3 = 6'h27;
  localparam logic [5:0] IDX_SENSE = 6'h28;

  // Byte addresses on APB; status is a local read-only addition
  localparam logic [7:0] ADDR_PRIO0  = {IDX_PRIO0, 2'b00};
  localparam logic [7:0] ADDR_PRIO1  = {IDX_PRIO1, 2'b00};
  localparam logic [7:0] ADDR_PRIO2  = {IDX_PRIO2, 2'b00};
  localparam logic [7:0] ADDR_PRIO3  = {IDX_PRIO3, 2'b00};
  localparam logic [7:0] ADDR_SENSE  = {IDX_SENSE, 2'b00};
  localparam logic [7:0] ADDR_STATUS = 8'h14;

  // ==========================================================
  // Reset values and fixed bits
  localparam logic [7:0]  PRIO_RESET    = 8'hFF;
  localparam logic [7:0]  PRIO3_RO_ONES = 8'hF0;
  localparam logic [7:0]  SENSE_RESET   = 8'h00;
  localparam logic [7:0]  SENSE_WMASK   = 8'hFC;
  localparam int          NUM_VEC       = 14;
  localparam int          NUM_GRP       = 4;

  // ==========================================================
  // Level codes (high bit, low bit)
  localparam logic [1:0] LVL0 = 2'b10;
  localparam logic [1:0] LVL1 = 2'b01;
  localparam logic [1:0] LVL2 = 2'b00;
  localparam logic [1:0] LVL3 = 2'b11;

  // ==========================================================
  // Vector indices and addresses
  localparam logic [3:0]  VEC_TIMEBASE = 4'h1;
  localparam logic [3:0]  VEC_EXT0     = 4'h2;
  localparam logic [3:0]  VEC_EXT3     = 4'h5;
  localparam logic [3:0]  VEC_SYNC     = 4'h7;
  localparam logic [3:0]  VEC_TIMA     = 4'h8;
  localparam logic [3:0]  VEC_TIMB     = 4'h9;
  localparam logic [3:0]  VEC_ASYNC    = 4'hA;
  localparam logic [15:0] VEC_ADDR_TOP = 16'hFFFA;
  localparam logic [15:0] VEC_RESET    = 16'hFFFE;
  localparam logic [15:0] VEC_TRAP     = 16'hFFFC;

  // Wake capability per vector index
  localparam logic [13:0] HALT_WAKE   = 14'h00BC;
  localparam logic [13:0] AHALT_FLASH = 14'h0002;
  localparam logic [13:0] AHALT_ROM   = 14'h00BE;

  // Sensitivity codes
  localparam logic [1:0] SNS_FALL_LOW = 2'b00;
  localparam logic [1:0] SNS_RISE     = 2'b01;
  localparam logic [1:0] SNS_FALL     = 2'b10;
  localparam logic [1:0] SNS_BOTH     = 2'b11;

  // Level code to numeric rank, 0 lowest
  function automatic logic [1:0] rank(input logic [1:0] code);
    unique case (code)
      LVL0:    rank = 2'd0;
      LVL1:    rank = 2'd1;
      LVL2:    rank = 2'd2;
      default: rank = 2'd3;
    endcase
  endfunction

endpackage

// [nipc_sense_if.sv]
`timescale 1ns/1ps
interface nipc_sense_if;
  logic [7:0] sel;
  logic [3:0] inv;
  logic [3:0] clr;
  logic [3:0] req;
  modport ctrl  (output sel, output inv, output clr, input req);
  modport sense (input sel, input inv, input clr, output req);
endinterface

// [nipc_pin_sense.sv]
`timescale 1ns/1ps
module nipc_pin_sense (
  // Clock and reset
  input  wire logic    clk,
  input  wire logic    rst,
  // Port pins, four per group
  input  wire logic [15:0] pins,
  // Control side
  nipc_sense_if.sense  sif
);

  logic [15:0] sync1_q;
  logic [15:0] sync2_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_q <= 16'hFFFF;
      sync2_q <= 16'hFFFF;
    end else begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
    end
  end

  // ==========================================================
  // Per group detection
  genvar g;
  generate
    for (g = 0; g < nipc_pkg::NUM_GRP; g++) begin : g_grp
      logic       sig;
      logic       prev_q;
      logic       latch_q;
      logic       edge_hit;
      logic [1:0] code;
      // Pins of a group are ORed before sensing
      assign sig  = (|sync2_q[4*g +: 4]) ^ sif.inv[g];
      assign code = sif.sel[2*g +: 2];
      always_comb begin
        unique case (code)
          nipc_pkg::SNS_RISE: edge_hit = sig & ~prev_q;
          nipc_pkg::SNS_BOTH: edge_hit = sig ^ prev_q;
          default:            edge_hit = ~sig & prev_q;
        endcase
      end
      always_ff @(posedge clk) begin
        if (rst) begin
          prev_q <= 1'b1;
        end else begin
          prev_q <= sig;
        end
      end
      // A new edge in the clearing cycle survives
      always_ff @(posedge clk) begin
        if (rst) begin
          latch_q <= 1'b0;
        end else if (edge_hit) begin
          latch_q <= 1'b1;
        end else if (sif.clr[g]) begin
          latch_q <= 1'b0;
        end
      end
      assign sif.req[g] = latch_q | ((code == nipc_pkg::SNS_FALL_LOW) & ~sig);
    end
  endgenerate

endmodule // nipc_pin_sense

// [nipc_cpu_model.sv]
`timescale 1ns/1ps
// ==========================================
// CPU stand-in: takes an offered request one cycle late
module nipc_cpu_model (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Request handshake
  input  wire logic ack_en,
  input  wire logic irq_req,
  output logic      irq_ack
);
  // Guard stops a second ack while the request is still dropping
  always_ff @(posedge clk) begin
    if (rst) irq_ack <= 1'b0;
    else irq_ack <= ack_en && irq_req && !irq_ack;
  end
endmodule // nipc_cpu_model

// [nested_interrupt_priority_ctrl_bench.sv]
`timescale 1ns/1ps
module nested_interrupt_priority_ctrl_bench;
  // ==========================================
  // Stimulus and observation
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, irq_ack, irq_req;
  logic [5:0]  ins = 6'h00;
  logic [1:0]  pop_cc_level = 2'b00;
  logic [4:0]  per = 5'h00;
  logic [15:0] ext_pins = 16'hFFFF;
  logic        ack_en = 1'b0;
  logic [3:0]  irq_index;
  logic [15:0] irq_vector, nmi_vector;
  logic        lh, ll, bm, bu, wake_halt, wake_ah;
  logic [1:0]  lvl;
  logic        last_err = 1'b0;
  int          mismatches = 0;
  int          n_compared = 0;

  assign lvl = {lh, ll};
  always #2.5 clk = ~clk;

  nipc_top DUT (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .enable_irq_instr(ins[0]), .disable_irq_instr(ins[1]),
    .wait_irq_instr(ins[2]), .halt_instr(ins[3]), .trap_instr(ins[4]),
    .pop_cc_instr(ins[5]), .pop_cc_level(pop_cc_level), .irq_ack(irq_ack),
    .clock_time_base_irq(per[0]), .sync_serial_irq(per[1]),
    .timer_a_irq(per[2]), .timer_b_irq(per[3]), .async_serial_unit(per[4]),
    .ext_pins(ext_pins), .irq_req(irq_req), .irq_index(irq_index),
    .irq_vector(irq_vector), .current_level_high_bit(lh),
    .current_level_low_bit(ll), .branch_if_masked(bm),
    .branch_if_unmasked(bu), .wake_halt(wake_halt),
    .wake_active_halt(wake_ah), .nmi_vector(nmi_vector)
  );

  nipc_cpu_model CPU (
    .clk(clk), .rst(rst), .ack_en(ack_en), .irq_req(irq_req), .irq_ack(irq_ack)
  );

  // ==========================================
  // Shared tasks
  task automatic end_sim;
    if (mismatches == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (i == 16) mismatches++;
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    chk(r, x);
    chk(32'(last_err), 32'h0);
  endtask

  // Strobe k is high for exactly one cycle; returns once the level settled
  task automatic instr(input int k, input logic [1:0] pl);
    @(posedge clk);
    ins[k] <= 1'b1;
    pop_cc_level <= pl;
    @(posedge clk);
    ins <= 6'h00;
    #1;
  endtask

  task automatic wait_irq;
    for (int i = 0; i < 20 && irq_req !== 1'b1; i++) @(posedge clk);
    #1;
  endtask

  task automatic wait_lvl(input logic [1:0] x);
    for (int i = 0; i < 20 && lvl !== x; i++) @(posedge clk);
    #1;
  endtask

  // ==========================================
  // Scenarios
  task automatic t_regs;
    logic [31:0] r;
    for (int i = 0; i < 4; i++) rd(nipc_pkg::ADDR_PRIO0 + 8'(4 * i), 32'hFF);
    rd(nipc_pkg::ADDR_SENSE, 32'h00);
    apb(1'b1, 8'h18, 32'h0, r);
    chk(32'(last_err), 32'h1);
    wr(nipc_pkg::ADDR_PRIO3, 32'h00);
    rd(nipc_pkg::ADDR_PRIO3, 32'hF0);
    wr(nipc_pkg::ADDR_PRIO1, 32'hCF);
    wr(nipc_pkg::ADDR_PRIO1, 32'h64);
    rd(nipc_pkg::ADDR_PRIO1, 32'h44);
    wr(nipc_pkg::ADDR_PRIO0, 32'hFE);
    rd(nipc_pkg::ADDR_PRIO0, 32'hFF);
    wr(nipc_pkg::ADDR_PRIO1, 32'hFF);
    wr(nipc_pkg::ADDR_PRIO3, 32'hFF);
  endtask

  task automatic t_sense;
    wr(nipc_pkg::ADDR_SENSE, 32'hFF);
    rd(nipc_pkg::ADDR_SENSE, 32'hFC);
    instr(0, 2'b00);
    wr(nipc_pkg::ADDR_SENSE, 32'h00);
    rd(nipc_pkg::ADDR_SENSE, 32'hFC);
    instr(1, 2'b00);
    wr(nipc_pkg::ADDR_SENSE, 32'h00);
    rd(nipc_pkg::ADDR_SENSE, 32'h00);
    // Flipping polarity in both-edge mode latched groups one and three
    rd(nipc_pkg::ADDR_STATUS, 32'h143);
    wr(nipc_pkg::ADDR_PRIO0, 32'hFF);
    wr(nipc_pkg::ADDR_PRIO1, 32'hFF);
    rd(nipc_pkg::ADDR_STATUS, 32'h3);
  endtask

  task automatic t_instr;
    int ks[7] = '{1, 0, 1, 2, 4, 3, 5};
    logic [1:0] xs[7] = '{2'b11, 2'b10, 2'b11, 2'b10, 2'b11, 2'b10, 2'b01};
    for (int i = 0; i < 7; i++) begin
      instr(ks[i], 2'b01);
      chk(32'(lvl), 32'(xs[i]));
      if (ks[i] == 4) chk(32'(nmi_vector), 32'hFFFC);
      @(posedge clk);
      #1;
      chk(32'({bm, bu}), xs[i] == 2'b11 ? 32'h2 : 32'h1);
    end
    instr(1, 2'b00);
  endtask

  task automatic t_irq;
    wr(nipc_pkg::ADDR_PRIO0, 32'hF7);
    instr(0, 2'b00);
    @(posedge clk);
    per[0] <= 1'b1;
    wait_irq;
    chk(32'(irq_index), 32'h1);
    chk(32'(irq_vector), 32'hFFF8);
    chk(32'({wake_halt, wake_ah}), 32'h1);
    @(posedge clk);
    ack_en <= 1'b1;
    wait_lvl(2'b01);
    chk(32'(lvl), 32'h1);
    wr(nipc_pkg::ADDR_PRIO0, 32'hF3);
    wait_lvl(2'b00);
    chk(32'(lvl), 32'h0);
    @(posedge clk);
    ack_en <= 1'b0;
    per[0] <= 1'b0;
    instr(1, 2'b00);
    wr(nipc_pkg::ADDR_PRIO0, 32'hFF);
  endtask

  task automatic t_arb;
    wr(nipc_pkg::ADDR_PRIO2, 32'hF0);
    instr(5, 2'b00);
    @(posedge clk);
    per[2] <= 1'b1;
    per[3] <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
    chk(32'(irq_req), 32'h0);
    chk(32'({wake_halt, wake_ah}), 32'h0);
    instr(0, 2'b00);
    wait_irq;
    chk(32'(irq_index), 32'h8);
    @(posedge clk);
    per <= 5'h00;
    instr(1, 2'b00);
    wr(nipc_pkg::ADDR_PRIO2, 32'hFF);
  endtask

  task automatic t_pin;
    logic [31:0] r;
    wr(nipc_pkg::ADDR_SENSE, 32'h10);
    wr(nipc_pkg::ADDR_PRIO0, 32'hDF);
    @(posedge clk);
    ext_pins[3:0] <= 4'h0;
    for (int i = 0; i < 20 && wake_halt !== 1'b1; i++) @(posedge clk);
    #1;
    chk(32'(wake_halt), 32'h1);
    instr(0, 2'b00);
    wait_irq;
    chk(32'(irq_vector), 32'hFFF6);
    instr(1, 2'b00);
    wr(nipc_pkg::ADDR_PRIO0, 32'hFF);
    apb(1'b0, nipc_pkg::ADDR_STATUS, 32'h0, r);
    chk(32'(r[6]), 32'h0);
    @(posedge clk);
    ext_pins[3:0] <= 4'hF;
    wr(nipc_pkg::ADDR_SENSE, 32'h20);
    repeat (6) @(posedge clk);
    apb(1'b0, nipc_pkg::ADDR_STATUS, 32'h0, r);
    chk(32'(r[9:4]), 32'h10);
    chk(32'(r[1:0]), 32'h3);
    wr(nipc_pkg::ADDR_SENSE, 32'h00);
  endtask

  // ==========================================
  // Sequence and watchdog
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_sense;
    t_instr;
    t_irq;
    t_arb;
    t_pin;
    end_sim;
  end

  // Whole sequence needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    end_sim;
  end
endmodule // nested_interrupt_priority_ctrl_bench
